/* rtl/vic_pkg.sv */
/*
 * constants shared by both ends of the vectored interrupt controller link:
 * register offsets, field positions, reset values, bus codes and level numbers.
 * assumes the controller occupies a 4 KB window selected by HSEL from outside.
 */
package vic_pkg;
	// ------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------
	localparam int NUM_SOURCES = 32;
	localparam int NUM_SLOTS = 16;
	localparam int NUM_LEVELS = 18;
	localparam int NONVEC_LEVEL = 16;
	localparam int CHAIN_LEVEL = 17;
	localparam int SLOT_CTRL_W = 6;
	localparam int SLOT_EN_BIT = 5;
	localparam int SLOT_SRC_LSB = 0;
	localparam int SLOT_SRC_W = 5;

	// ------------------------------------------------------------
	// register offsets (byte addresses within the window) and slot page numbers (HADDR bits 11:8)
	// ------------------------------------------------------------
	localparam logic [11:0] OFS_NORMAL_STATUS = 12'h000;
	localparam logic [11:0] OFS_FAST_STATUS = 12'h004;
	localparam logic [11:0] OFS_RAW_STATUS = 12'h008;
	localparam logic [11:0] OFS_FAST_SELECT = 12'h00c;
	localparam logic [11:0] OFS_ENABLE_SET = 12'h010;
	localparam logic [11:0] OFS_ENABLE_CLEAR = 12'h014;
	localparam logic [11:0] OFS_SOFT_SET = 12'h018;
	localparam logic [11:0] OFS_SOFT_CLEAR = 12'h01c;
	localparam logic [11:0] OFS_HANDLER_ADDR = 12'h030;
	localparam logic [11:0] OFS_DEFAULT_ADDR = 12'h034;
	localparam logic [3:0] PAGE_SLOT_ADDR = 4'h1;
	localparam logic [3:0] PAGE_SLOT_CTRL = 4'h2;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [SLOT_CTRL_W-1:0] RST_SLOT_CTRL = 6'h00;
	localparam logic [NUM_LEVELS-1:0] RST_IN_SERVICE = 18'h00000;

	// ------------------------------------------------------------
	// bus codes
	// ------------------------------------------------------------
	localparam logic [1:0] HTRANS_IDLE = 2'h0;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HRESP_OKAY = 2'h0;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage

/* rtl/vic_bus_if.sv */
/*
 * link between the controller and the processor core: a single-slave
 * AHB segment plus the two active-low interrupt request lines.
 * assumes one clock shared by both ends; no clocking block.
 */
`timescale 1ns/1ps
`default_nettype none
interface vic_bus_if;
	logic HSEL;
	logic [31:0] HADDR;
	logic HWRITE;
	logic [1:0] HTRANS;
	logic [2:0] HSIZE;
	logic [31:0] HWDATA;
	logic [31:0] HRDATA;
	logic HREADY;
	logic [1:0] HRESP;
	logic normalIrqOutN;
	logic fastIrqOutN;

	modport device (
		input HSEL, HADDR, HWRITE, HTRANS, HSIZE, HWDATA,
		output HRDATA, HREADY, HRESP, normalIrqOutN, fastIrqOutN
	);
	modport core (
		output HSEL, HADDR, HWRITE, HTRANS, HSIZE, HWDATA,
		input HRDATA, HREADY, HRESP, normalIrqOutN, fastIrqOutN
	);
endinterface
`default_nettype wire

/* rtl/vector_slot.sv */
/*
 * one vector slot: decodes its control word into a request and a claim
 * mask on the normal request vector.
 * assumes the control word and handler address are held by the parent.
 */
`timescale 1ns/1ps
`default_nettype none
module vector_slot (
	input wire logic [vic_pkg::NUM_SOURCES-1:0] normalReq,
	input wire logic [vic_pkg::SLOT_CTRL_W-1:0] control,
	output logic active,
	output logic [vic_pkg::NUM_SOURCES-1:0] claim
);
	wire logic slotEnabled;
	wire logic [vic_pkg::SLOT_SRC_W-1:0] sourceIndex;

	assign slotEnabled = control[vic_pkg::SLOT_EN_BIT];
	assign sourceIndex = control[vic_pkg::SLOT_SRC_LSB +: vic_pkg::SLOT_SRC_W];
	// only enabled, normal-routed sources can reach a slot
	assign active = slotEnabled & normalReq[sourceIndex];
	assign claim = slotEnabled ? (32'h0000_0001 << sourceIndex) : 32'h0000_0000;
endmodule
`default_nettype wire

/* rtl/vic_device.sv */
/*
 * vectored interrupt controller: request logic, 16 vector slots, priority
 * stage with service mask, daisy chain, and an AHB slave register set.
 * assumes HSEL decodes a 4 KB window and the core is the only master.
 */
`timescale 1ns/1ps
`default_nettype none
module vic_device (
	input wire logic core_clk,
	input wire logic reset,
	vic_bus_if.device bus,
	input wire logic [vic_pkg::NUM_SOURCES-1:0] sourceRequestLines,
	input wire logic chainNormalIrqInN,
	input wire logic chainFastIrqInN,
	input wire logic [31:0] chainVectorAddressIn,
	output logic [31:0] chainVectorAddressOut
);
	localparam int NS = vic_pkg::NUM_SOURCES;
	localparam int NL = vic_pkg::NUM_LEVELS;
	localparam int NV = vic_pkg::NUM_SLOTS;

	typedef enum logic [3:0] {
		PH_IDLE = 4'b0001,
		PH_WRITE = 4'b0010,
		PH_READWAIT = 4'b0100,
		PH_READDONE = 4'b1000
	} phase_t;

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------
	function automatic logic [NL-1:0] lowestOne(input logic [NL-1:0] v);
		return v & (~v + 18'h00001);
	endfunction

	// levels strictly above the highest one in service
	function automatic logic [NL-1:0] allowedLevels(input logic [NL-1:0] s);
		return lowestOne(s) - 18'h00001;
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [NS-1:0] sourceEnableReg;
	logic [NS-1:0] fastPathSelectReg;
	logic [NS-1:0] softRequestReg;
	logic [31:0] defaultAddrReg;
	logic [31:0] slotAddrReg [NV];
	logic [vic_pkg::SLOT_CTRL_W-1:0] slotCtrlReg [NV];
	logic [NL-1:0] inServiceReg;
	phase_t phaseReg;
	phase_t phaseNext;
	logic [11:0] addrReg;
	logic [31:0] rdataReg;
	logic readyReg;
	logic [31:0] chainAddrReg;

	// ------------------------------------------------------------
	// request logic
	// ------------------------------------------------------------
	wire logic [NS-1:0] rawReq;
	wire logic [NS-1:0] enabledReq;
	wire logic [NS-1:0] fastReq;
	wire logic [NS-1:0] normalReq;
	wire logic [NV-1:0] slotActive;
	wire logic [NS-1:0] slotClaim [NV];
	logic [NS-1:0] claimedAll;
	wire logic nonVectored;
	wire logic [NL-1:0] levelReq;
	wire logic [NL-1:0] eligible;
	wire logic [NL-1:0] winner;
	wire logic [NV-1:0] slotRequestFlag;
	logic [31:0] winAddr;

	assign rawReq = sourceRequestLines | softRequestReg;
	assign enabledReq = rawReq & sourceEnableReg;
	assign fastReq = enabledReq & fastPathSelectReg;
	assign normalReq = enabledReq & ~fastPathSelectReg;

	genvar gi;
	generate
		for (gi = 0; gi < NV; gi++) begin : g_slot
			vector_slot vector_slot_i (
				.normalReq(normalReq),
				.control(slotCtrlReg[gi]),
				.active(slotActive[gi]),
				.claim(slotClaim[gi])
			);
		end
	endgenerate

	always_comb begin
		claimedAll = '0;
		for (int i = 0; i < NV; i++) begin
			claimedAll = claimedAll | slotClaim[i];
		end
	end

	// unclaimed normal requests share one level, below every slot and above the chain
	assign nonVectored = |(normalReq & ~claimedAll);
	assign levelReq = {~chainNormalIrqInN, nonVectored, slotActive};
	assign eligible = levelReq & allowedLevels(inServiceReg);
	assign winner = lowestOne(eligible);
	assign slotRequestFlag = winner[NV-1:0];

	always_comb begin
		winAddr = defaultAddrReg;
		for (int i = 0; i < NV; i++) begin
			if (slotRequestFlag[i]) begin
				winAddr = slotAddrReg[i];
			end
		end
		if (winner[vic_pkg::CHAIN_LEVEL]) begin
			winAddr = chainVectorAddressIn;
		end
	end

	// no flop on these paths: they work with the clock stopped
	assign bus.normalIrqOutN = ~|eligible;
	assign bus.fastIrqOutN = ~(|fastReq | ~chainFastIrqInN);

	// ------------------------------------------------------------
	// bus slave
	// ------------------------------------------------------------
	wire logic accept;
	wire logic writeStrobe;
	wire logic readStrobe;
	wire logic isSlotAddr;
	wire logic isSlotCtrl;
	wire logic [3:0] slotIndex;
	logic [31:0] readData;

	assign accept = bus.HSEL & bus.HTRANS[1] & readyReg;
	assign writeStrobe = (phaseReg == PH_WRITE);
	assign readStrobe = (phaseReg == PH_READWAIT);
	assign slotIndex = addrReg[5:2];
	assign isSlotAddr = (addrReg[11:8] == vic_pkg::PAGE_SLOT_ADDR) && (addrReg[7:6] == 2'h0);
	assign isSlotCtrl = (addrReg[11:8] == vic_pkg::PAGE_SLOT_CTRL) && (addrReg[7:6] == 2'h0);

	always_comb begin
		case (phaseReg)
			PH_READWAIT: begin
				phaseNext = PH_READDONE;
			end
			default: begin
				if (accept) begin
					phaseNext = bus.HWRITE ? PH_WRITE : PH_READWAIT;
				end else begin
					phaseNext = PH_IDLE;
				end
			end
		endcase
	end

	always_comb begin
		readData = vic_pkg::RST_WORD;
		case (addrReg)
			vic_pkg::OFS_NORMAL_STATUS: readData = normalReq;
			vic_pkg::OFS_FAST_STATUS: readData = fastReq;
			vic_pkg::OFS_RAW_STATUS: readData = rawReq;
			vic_pkg::OFS_FAST_SELECT: readData = fastPathSelectReg;
			vic_pkg::OFS_ENABLE_SET: readData = sourceEnableReg;
			vic_pkg::OFS_SOFT_SET: readData = softRequestReg;
			vic_pkg::OFS_HANDLER_ADDR: readData = winAddr;
			vic_pkg::OFS_DEFAULT_ADDR: readData = defaultAddrReg;
			default: begin
				if (isSlotAddr) begin
					readData = slotAddrReg[slotIndex];
				end else if (isSlotCtrl) begin
					readData = {26'h0000000, slotCtrlReg[slotIndex]};
				end
			end
		endcase
	end

	wire logic [NS-1:0] wdata;
	wire logic handlerRead;
	wire logic handlerWrite;

	assign wdata = bus.HWDATA;
	assign handlerRead = readStrobe && (addrReg == vic_pkg::OFS_HANDLER_ADDR);
	assign handlerWrite = writeStrobe && (addrReg == vic_pkg::OFS_HANDLER_ADDR);

	always_ff @(posedge core_clk) begin
		if (reset) begin
			phaseReg <= PH_IDLE;
			readyReg <= 1'b1;
			addrReg <= 12'h000;
			rdataReg <= vic_pkg::RST_WORD;
			chainAddrReg <= vic_pkg::RST_WORD;
		end else begin
			phaseReg <= phaseNext;
			readyReg <= (phaseNext != PH_READWAIT);
			if (accept) begin
				addrReg <= bus.HADDR[11:0];
			end
			if (readStrobe) begin
				rdataReg <= readData;
			end
			chainAddrReg <= winAddr;
		end
	end

	// ------------------------------------------------------------
	// register file
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (reset) begin
			sourceEnableReg <= vic_pkg::RST_WORD;
			fastPathSelectReg <= vic_pkg::RST_WORD;
			softRequestReg <= vic_pkg::RST_WORD;
			defaultAddrReg <= vic_pkg::RST_WORD;
			inServiceReg <= vic_pkg::RST_IN_SERVICE;
		end else begin
			if (writeStrobe) begin
				case (addrReg)
					vic_pkg::OFS_FAST_SELECT: fastPathSelectReg <= wdata;
					vic_pkg::OFS_ENABLE_SET: sourceEnableReg <= sourceEnableReg | wdata;
					vic_pkg::OFS_ENABLE_CLEAR: sourceEnableReg <= sourceEnableReg & ~wdata;
					vic_pkg::OFS_SOFT_SET: softRequestReg <= softRequestReg | wdata;
					vic_pkg::OFS_SOFT_CLEAR: softRequestReg <= softRequestReg & ~wdata;
					vic_pkg::OFS_DEFAULT_ADDR: defaultAddrReg <= wdata;
					default: begin
					end
				endcase
			end
			if (handlerRead) begin
				inServiceReg <= inServiceReg | winner;
			end else if (handlerWrite) begin
				inServiceReg <= inServiceReg & ~lowestOne(inServiceReg);
			end
		end
	end

	generate
		for (gi = 0; gi < NV; gi++) begin : g_slot_regs
			always_ff @(posedge core_clk) begin
				if (reset) begin
					slotAddrReg[gi] <= vic_pkg::RST_WORD;
					slotCtrlReg[gi] <= vic_pkg::RST_SLOT_CTRL;
				end else if (writeStrobe && slotIndex == 4'(gi)) begin
					if (isSlotAddr) begin
						slotAddrReg[gi] <= wdata;
					end
					if (isSlotCtrl) begin
						slotCtrlReg[gi] <= wdata[vic_pkg::SLOT_CTRL_W-1:0];
					end
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign bus.HRDATA = rdataReg;
	assign bus.HREADY = readyReg;
	assign bus.HRESP = vic_pkg::HRESP_OKAY;
	assign chainVectorAddressOut = chainAddrReg;
endmodule
`default_nettype wire

/* rtl/vic_host.sv */
/*
 * processor-core end: turns single word commands into AHB transfers
 * and samples the two interrupt request lines.
 * assumes the controller is the only slave and HSEL selects it.
 */
`timescale 1ns/1ps
`default_nettype none
module vic_host (
	input wire logic core_clk,
	input wire logic reset,
	vic_bus_if.core bus,
	input wire logic cmdValid,
	input wire logic cmdWrite,
	input wire logic [31:0] cmdAddr,
	input wire logic [31:0] cmdWdata,
	output logic cmdReady,
	output logic rspValid,
	output logic [31:0] rspRdata,
	output logic normalIrq,
	output logic fastIrq
);
	typedef enum logic [2:0] {
		H_IDLE = 3'b001,
		H_ADDR = 3'b010,
		H_DATA = 3'b100
	} host_state_t;

	host_state_t stateReg;
	logic selReg;
	logic writeReg;
	logic [1:0] transReg;
	logic [31:0] addrReg;
	logic [31:0] wdataHoldReg;
	logic [31:0] hwdataReg;
	logic readyReg;
	logic rspValidReg;
	logic [31:0] rspRdataReg;
	logic normalIrqReg;
	logic fastIrqReg;

	wire logic take;
	assign take = cmdValid & readyReg;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			stateReg <= H_IDLE;
			selReg <= 1'b0;
			writeReg <= 1'b0;
			transReg <= vic_pkg::HTRANS_IDLE;
			addrReg <= vic_pkg::RST_WORD;
			wdataHoldReg <= vic_pkg::RST_WORD;
			hwdataReg <= vic_pkg::RST_WORD;
			readyReg <= 1'b1;
			rspValidReg <= 1'b0;
			rspRdataReg <= vic_pkg::RST_WORD;
			normalIrqReg <= 1'b0;
			fastIrqReg <= 1'b0;
		end else begin
			rspValidReg <= 1'b0;
			normalIrqReg <= ~bus.normalIrqOutN;
			fastIrqReg <= ~bus.fastIrqOutN;
			case (stateReg)
				H_IDLE: begin
					if (take) begin
						stateReg <= H_ADDR;
						selReg <= 1'b1;
						writeReg <= cmdWrite;
						transReg <= vic_pkg::HTRANS_NONSEQ;
						addrReg <= cmdAddr;
						wdataHoldReg <= cmdWdata;
						readyReg <= 1'b0;
					end
				end
				H_ADDR: begin
					if (bus.HREADY) begin
						stateReg <= H_DATA;
						selReg <= 1'b0;
						transReg <= vic_pkg::HTRANS_IDLE;
						hwdataReg <= wdataHoldReg;
					end
				end
				H_DATA: begin
					if (bus.HREADY) begin
						stateReg <= H_IDLE;
						rspValidReg <= 1'b1;
						rspRdataReg <= writeReg ? vic_pkg::RST_WORD : bus.HRDATA;
						readyReg <= 1'b1;
					end
				end
				default: begin
					stateReg <= H_IDLE;
					readyReg <= 1'b1;
				end
			endcase
		end
	end

	assign bus.HSEL = selReg;
	assign bus.HADDR = addrReg;
	assign bus.HWRITE = writeReg;
	assign bus.HTRANS = transReg;
	assign bus.HSIZE = vic_pkg::HSIZE_WORD;
	assign bus.HWDATA = hwdataReg;
	assign cmdReady = readyReg;
	assign rspValid = rspValidReg;
	assign rspRdata = rspRdataReg;
	assign normalIrq = normalIrqReg;
	assign fastIrq = fastIrqReg;
endmodule
`default_nettype wire

/* sim/vic_link_sva.sv */
/*
 * checks on the link between the controller and the core end.
 * assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
module vic_link_sva (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic HSEL,
	input wire logic HWRITE,
	input wire logic [1:0] HTRANS,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HRDATA,
	input wire logic HREADY,
	input wire logic [1:0] HRESP
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	logic take;
	assign take = HSEL && HTRANS[1] && HREADY;
	// ----------------------------------------
	// sequences
	// ----------------------------------------
	sequence s_read_data;
		!HREADY ##1 HREADY;
	endsequence
	sequence s_quiet3;
		!HSEL [*3];
	endsequence
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	a_resp_always_okay: assert property (HRESP == vic_pkg::HRESP_OKAY)
		else $error("response code not okay");
	a_read_one_wait: assert property (take && !HWRITE |=> s_read_data)
		else $error("read data phase length wrong");
	a_write_no_wait: assert property (take && HWRITE |=> HREADY)
		else $error("write data phase stalled");
	a_ready_after_reset: assert property ($fell(reset) |-> HREADY)
		else $error("not ready after reset");
	a_rdata_hold: assert property (!$stable(HRDATA) |-> !$past(HREADY))
		else $error("read data changed outside a read");
	a_addr_when_ready: assert property (HSEL && HTRANS[1] |-> HREADY)
		else $error("address phase during wait state");
	a_read_gap: assert property (take && !HWRITE |=> s_quiet3)
		else $error("transfer overlaps a read");
	a_write_gap: assert property (take && HWRITE |=> !HSEL [*2])
		else $error("transfer overlaps a write");
	a_word_nonseq: assert property (HSEL |-> HTRANS == vic_pkg::HTRANS_NONSEQ
		&& HSIZE == vic_pkg::HSIZE_WORD)
		else $error("bad transfer type or size");
endmodule
`default_nettype wire

/* sim/vectored_interrupt_controller_test.sv */
/*
 * self-checking bench: controller and core end joined by the link.
 * assumes a 50 MHz clock and the controller window at the top 4 KB.
 */
`timescale 1ns/1ps
`default_nettype none
module vectored_interrupt_controller_test;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic [31:0] srcLines = 32'h0;
	logic chainNormN = 1'b1;
	logic chainFastN = 1'b1;
	logic [31:0] chainAddr = 32'h0;
	logic [31:0] chainOut;
	logic hostNormal;
	logic hostFast;
	logic cmdValid = 1'b0;
	logic cmdWrite = 1'b0;
	logic [31:0] cmdAddr = 32'h0;
	logic [31:0] cmdWdata = 32'h0;
	logic cmdReady;
	logic rspValid;
	logic [31:0] rspRdata;
	logic [31:0] expQ [$];
	logic [31:0] seed = 32'h20;
	int n_fail = 0;
	int checks_done = 0;
	int cycles = 0;

	initial forever #10 core_clk = ~core_clk;

	vic_bus_if link ();
	vic_device vic_device_i (.core_clk(core_clk), .reset(reset), .bus(link),
		.sourceRequestLines(srcLines), .chainNormalIrqInN(chainNormN),
		.chainFastIrqInN(chainFastN), .chainVectorAddressIn(chainAddr),
		.chainVectorAddressOut(chainOut));
	vic_host vic_host_i (.core_clk(core_clk), .reset(reset), .bus(link),
		.cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdAddr(cmdAddr),
		.cmdWdata(cmdWdata), .cmdReady(cmdReady), .rspValid(rspValid),
		.rspRdata(rspRdata), .normalIrq(hostNormal), .fastIrq(hostFast));
	vic_link_sva vic_link_sva_i (.core_clk(core_clk), .reset(reset),
		.HSEL(link.HSEL), .HWRITE(link.HWRITE), .HTRANS(link.HTRANS),
		.HSIZE(link.HSIZE), .HRDATA(link.HRDATA), .HREADY(link.HREADY),
		.HRESP(link.HRESP));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] next_rand();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic report_err(input string msg);
		n_fail++;
		$display("Error %0t: %s", $time, msg);
	endtask

	task automatic close_out();
		$display("checks %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) report_err($sformatf("data %h, expected %h", got, exp));
	endtask

	// expected pin levels, active low; core end flags one edge later
	task automatic cmp_irq(input logic expN, input logic expF);
		#1;
		checks_done++;
		if (link.normalIrqOutN !== expN || link.fastIrqOutN !== expF) begin
			report_err("interrupt line level wrong");
		end
		@(posedge core_clk);
		#1;
		checks_done++;
		if (hostNormal !== ~expN || hostFast !== ~expF) begin
			report_err("core end interrupt flags wrong");
		end
		@(negedge core_clk);
	endtask

	// called at a falling edge, returns at the falling edge showing rspValid
	task automatic xfer(input logic wr, input logic [11:0] ofs, input logic [31:0] d,
		input logic [31:0] exp);
		int n;
		n = 0;
		while (cmdReady !== 1'b1 && n < 20) begin
			@(negedge core_clk);
			n++;
		end
		expQ.push_back(exp);
		cmdWrite = wr;
		cmdAddr = 32'hfffff000 | {20'h0, ofs};
		cmdWdata = d;
		cmdValid = 1'b1;
		@(negedge core_clk);
		cmdValid = 1'b0;
		n = 0;
		while (rspValid !== 1'b1 && n < 20) begin
			@(negedge core_clk);
			n++;
		end
		if (n == 20) report_err("no response");
	endtask

	task automatic wr(input logic [11:0] ofs, input logic [31:0] d);
		xfer(1'b1, ofs, d, 32'h0);
	endtask

	task automatic rd(input logic [11:0] ofs, input logic [31:0] exp);
		xfer(1'b0, ofs, 32'h0, exp);
	endtask

	// ----------------------------------------
	// response monitor and watchdog
	// ----------------------------------------
	always @(negedge core_clk) begin
		if (rspValid === 1'b1) begin
			if (expQ.size() == 0) report_err("response with nothing expected");
			else cmp_word(rspRdata, expQ.pop_front());
		end
	end

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			report_err("timeout");
			close_out();
		end
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		int a;
		int b;
		int sa;
		int sb;
		int sk;
		logic [31:0] addrA;
		logic [31:0] addrB;
		logic [31:0] dflt;
		repeat (5) @(negedge core_clk);
		reset = 1'b0;
		@(negedge core_clk);
		cmp_irq(1'b1, 1'b1);
		cmp_word(chainOut, 32'h0);
		rd(12'h010, 32'h0);
		rd(12'h018, 32'h0);
		rd(12'h200, 32'h0);
		rd(12'h040, 32'h0);
		$display("test reset values done");

		wr(12'h010, 32'h3);
		wr(12'h00c, 32'h1);
		srcLines = 32'h1;
		cmp_irq(1'b1, 1'b0);
		srcLines = 32'h3;
		cmp_irq(1'b0, 1'b0);
		rd(12'h008, 32'h3);
		rd(12'h004, 32'h1);
		rd(12'h000, 32'h2);
		srcLines = 32'h0;
		chainFastN = 1'b0;
		cmp_irq(1'b1, 1'b0);
		chainFastN = 1'b1;
		chainNormN = 1'b0;
		chainAddr = next_rand();
		cmp_irq(1'b0, 1'b1);
		cmp_word(chainOut, chainAddr);
		rd(12'h030, chainAddr);
		cmp_irq(1'b1, 1'b1);
		chainNormN = 1'b1;
		wr(12'h030, 32'h0);
		wr(12'h014, 32'h3);
		wr(12'h00c, 32'h0);
		$display("test routing and chain done");

		wr(12'h010, 32'h10);
		wr(12'h018, 32'h10);
		cmp_irq(1'b0, 1'b1);
		rd(12'h018, 32'h10);
		wr(12'h01c, 32'h10);
		cmp_irq(1'b1, 1'b1);
		wr(12'h014, 32'h10);
		$display("test soft requests done");

		for (int t = 0; t < 4; t++) begin
			a = int'(next_rand() & 32'h7);
			b = 8 + int'(next_rand() & 32'h7);
			sa = int'(next_rand() & 32'h7);
			sb = 8 + int'(next_rand() & 32'h7);
			sk = 24 + int'(next_rand() & 32'h7);
			addrA = next_rand();
			addrB = next_rand();
			dflt = next_rand();
			wr(12'(12'h100 + 4 * a), addrA);
			wr(12'(12'h100 + 4 * b), addrB);
			wr(12'(12'h200 + 4 * a), 32'h20 | sa);
			wr(12'(12'h200 + 4 * b), 32'h20 | sb);
			wr(12'h034, dflt);
			srcLines = (32'h1 << sa) | (32'h1 << sb) | (32'h1 << sk);
			wr(12'h010, srcLines);
			wr(12'h00c, 32'h1 << sa);
			rd(12'h030, addrB);
			wr(12'h030, 32'h0);
			wr(12'h00c, 32'h0);
			cmp_irq(1'b0, 1'b1);
			rd(12'h030, addrA);
			cmp_irq(1'b1, 1'b1);
			srcLines[sa] = 1'b0;
			wr(12'h030, 32'h0);
			cmp_irq(1'b0, 1'b1);
			rd(12'h030, addrB);
			srcLines[sb] = 1'b0;
			wr(12'h030, 32'h0);
			rd(12'h030, dflt);
			srcLines = 32'h0;
			wr(12'h030, 32'h0);
			cmp_irq(1'b1, 1'b1);
			wr(12'h014, 32'hffffffff);
			wr(12'(12'h200 + 4 * a), 32'h0);
			wr(12'(12'h200 + 4 * b), 32'h0);
		end
		$display("test vector priority done");
		close_out();
	end
endmodule
`default_nettype wire
